// File: bcu_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module bcu_chk
	import bcu_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               rstn,
	input wire logic               start,
	input wire logic               word_mode,
	input wire logic [COUNT_W-1:0] word_count_reg_in,
	input wire logic [FLAG_W-1:0]  flags_in,
	input wire logic               busy,
	input wire logic               done,
	input wire logic [COUNT_W-1:0] word_count_reg_out,
	input wire logic [ADDR_W-1:0]  source_pointer_reg_out,
	input wire logic [ADDR_W-1:0]  dest_pointer_reg_out,
	input wire logic [FLAG_W-1:0]  flags_out,
	input wire logic               mem_req,
	input wire logic               mem_we,
	input wire logic [ADDR_W-1:0]  mem_addr,
	input wire logic [DATA_W-1:0]  mem_wdata,
	input wire logic [DATA_W-1:0]  mem_rdata,
	input wire logic               mem_ack
);
	logic [DATA_W-1:0] rd_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// Last byte fetched, owed to the next write
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			rd_r <= DATA_RST;
		else if (mem_req && mem_ack && !mem_we)
			rd_r <= mem_rdata;

	property p_flag_take;
		start && !busy |=> flags_out == $past(flags_in);
	endproperty
	a_flag_take: assert property (p_flag_take) else $error("flags");
	property p_flag_keep;
		busy |=> $stable(flags_out);
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("flags");
	property p_zero;
		start && !busy && word_count_reg_in[CNT_LOW_MSB:0] == 8'h00
		&& (!word_mode || word_count_reg_in[15:CNT_HIGH_LSB] == 8'h00)
		|=> (busy && !mem_req)[*7] ##1 (done && !busy);
	endproperty
	a_zero: assert property (p_zero) else $error("zero count");
	property p_rd;
		mem_req && !mem_we |-> mem_addr == source_pointer_reg_out;
	endproperty
	a_rd: assert property (p_rd) else $error("read addr");
	property p_wr;
		mem_req && mem_we |-> mem_addr == dest_pointer_reg_out
		&& mem_wdata == rd_r;
	endproperty
	a_wr: assert property (p_wr) else $error("write");
	property p_hold;
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
	endproperty
	a_hold: assert property (p_hold) else $error("req hold");
	property p_seq;
		mem_req && mem_ack && !mem_we |=> !mem_req[*2] ##1 (mem_req && mem_we);
	endproperty
	a_seq: assert property (p_seq) else $error("byte slot");
	property p_step;
		mem_req && mem_ack && mem_we |=>
		source_pointer_reg_out == $past(source_pointer_reg_out) + 16'h0001
		&& dest_pointer_reg_out == $past(dest_pointer_reg_out) + 16'h0001
		&& word_count_reg_out == $past(word_count_reg_out) - 16'h0001;
	endproperty
	a_step: assert property (p_step) else $error("step");
	property p_done;
		done |-> !busy ##1 !done;
	endproperty
	a_done: assert property (p_done) else $error("done");
	c_zero: cover property (start && !busy && word_count_reg_in == 16'h0000);
	c_stall: cover property (mem_req && !mem_ack);
	c_write: cover property (mem_req && mem_we && mem_ack);
endmodule : bcu_chk

bind bcu_block_copy bcu_chk i_chk (.*);

`default_nettype wire

// File: bcu_block_copy.sv
// Behaviour
// - Byte form: while low count byte nonzero, read source byte, write destination.
// - After each byte: source and destination pointers plus one, count minus one.
// - Word form uses full 16-bit count; zero count moves nothing, instruction ends.
// - Each form takes 8 fixed states plus 4 per byte moved.
// - Fixed timing assumes on-chip memory; slower memory adds wait cycles.
`timescale 1ns/10ps
`default_nettype none

module bcu_block_copy
	import bcu_pkg::*;
#(
	parameter int FIFO_D = FIFO_DEPTH
) (
	input  wire logic               core_clk,
	input  wire logic               rstn,
	input  wire logic               start,
	input  wire logic               word_mode,
	input  wire logic [COUNT_W-1:0] word_count_reg_in,
	input  wire logic [ADDR_W-1:0]  source_pointer_reg_in,
	input  wire logic [ADDR_W-1:0]  dest_pointer_reg_in,
	input  wire logic [FLAG_W-1:0]  flags_in,
	output logic                    busy,
	output logic                    done,
	output logic [COUNT_W-1:0]      word_count_reg_out,
	output logic [ADDR_W-1:0]       source_pointer_reg_out,
	output logic [ADDR_W-1:0]       dest_pointer_reg_out,
	output logic [FLAG_W-1:0]       flags_out,
	output logic                    mem_req,
	output logic                    mem_we,
	output logic [ADDR_W-1:0]       mem_addr,
	output logic [DATA_W-1:0]       mem_wdata,
	input  wire logic [DATA_W-1:0]  mem_rdata,
	input  wire logic               mem_ack
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		bcu_state_e         state;
		logic [PRE_W-1:0]   pre_cnt;
		logic               word_mode;
		logic [COUNT_W-1:0] count;
		logic [ADDR_W-1:0]  src;
		logic [ADDR_W-1:0]  dst;
		logic [FLAG_W-1:0]  flags;
		logic               busy;
		logic               done;
		logic               req;
		logic               we;
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  wdata;
		logic               push_valid;
		logic [DATA_W-1:0]  push_data;
		logic               pop_ready;
	} bcu_state_s;

	localparam bcu_state_s STATE_RST = '{
		state:      ST_IDLE,
		pre_cnt:    '0,
		word_mode:  1'b0,
		count:      COUNT_RST,
		src:        ADDR_RST,
		dst:        ADDR_RST,
		flags:      FLAG_RST,
		busy:       1'b0,
		done:       1'b0,
		req:        1'b0,
		we:         1'b0,
		addr:       ADDR_RST,
		wdata:      DATA_RST,
		push_valid: 1'b0,
		push_data:  DATA_RST,
		pop_ready:  1'b0
	};

	bcu_state_s st_r;
	bcu_state_s st_nxt;

	// ------------------------------------------------------------
	// Staging buffer between read and write halves
	// ------------------------------------------------------------
	bcu_fifo_if #(.W(DATA_W)) fq ();

	bcu_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.core_clk (core_clk),
		.rstn     (rstn),
		.f        (fq.fifo)
	);

	assign fq.push_valid = st_r.push_valid;
	assign fq.push_data  = st_r.push_data;
	assign fq.pop_ready  = st_r.pop_ready;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Bytes still to move under the form in effect
	function automatic logic [COUNT_W-1:0] remaining(
		input logic               wm,
		input logic [COUNT_W-1:0] c
	);
		if (wm) begin
			return c;
		end
		return {{(COUNT_W-CNT_LOW_MSB-1){1'b0}}, c[CNT_LOW_MSB:0]};
	endfunction : remaining

	// Byte form wraps only the low half, the high half is left alone
	function automatic logic [COUNT_W-1:0] decrement(
		input logic               wm,
		input logic [COUNT_W-1:0] c
	);
		logic [CNT_LOW_MSB:0] low;
		low = c[CNT_LOW_MSB:0] - 1'b1;
		if (wm) begin
			return c - 1'b1;
		end
		return {c[COUNT_W-1:CNT_HIGH_LSB], low};
	endfunction : decrement

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		logic [COUNT_W-1:0] cnt_dec;
		logic [ADDR_W-1:0]  src_inc;
		logic [ADDR_W-1:0]  dst_inc;
		cnt_dec = decrement(st_r.word_mode, st_r.count);
		src_inc = st_r.src + 1'b1;
		dst_inc = st_r.dst + 1'b1;
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		case (st_r.state)
			ST_IDLE: begin
				if (start) begin
					st_nxt.word_mode = word_mode;
					st_nxt.count     = word_count_reg_in;
					st_nxt.src       = source_pointer_reg_in;
					st_nxt.dst       = dest_pointer_reg_in;
					st_nxt.flags     = flags_in;
					st_nxt.busy      = 1'b1;
					st_nxt.pre_cnt   = PRE_LOAD;
					st_nxt.state     = ST_PRE;
				end
			end
			ST_PRE: begin
				if (st_r.pre_cnt != '0) begin
					st_nxt.pre_cnt = st_r.pre_cnt - 1'b1;
				end else if (remaining(st_r.word_mode, st_r.count) == '0) begin
					st_nxt.busy  = 1'b0;
					st_nxt.done  = 1'b1;
					st_nxt.state = ST_IDLE;
				end else begin
					st_nxt.req   = 1'b1;
					st_nxt.we    = 1'b0;
					st_nxt.addr  = st_r.src;
					st_nxt.state = ST_RD;
				end
			end
			ST_RD: begin
				if (mem_ack) begin
					st_nxt.req        = 1'b0;
					st_nxt.push_valid = 1'b1;
					st_nxt.push_data  = mem_rdata;
					st_nxt.state      = ST_PUSH;
				end
			end
			ST_PUSH: begin
				// Full buffer stalls the copy instead of dropping a byte
				if (fq.push_ready) begin
					st_nxt.push_valid = 1'b0;
					st_nxt.pop_ready  = 1'b1;
					st_nxt.state      = ST_POP;
				end
			end
			ST_POP: begin
				if (fq.pop_valid) begin
					st_nxt.pop_ready = 1'b0;
					st_nxt.wdata     = fq.pop_data;
					st_nxt.req       = 1'b1;
					st_nxt.we        = 1'b1;
					st_nxt.addr      = st_r.dst;
					st_nxt.state     = ST_WR;
				end
			end
			ST_WR: begin
				if (mem_ack) begin
					st_nxt.src   = src_inc;
					st_nxt.dst   = dst_inc;
					st_nxt.count = cnt_dec;
					st_nxt.we    = 1'b0;
					if (remaining(st_r.word_mode, cnt_dec) == '0) begin
						st_nxt.req   = 1'b0;
						st_nxt.busy  = 1'b0;
						st_nxt.done  = 1'b1;
						st_nxt.state = ST_IDLE;
					end else begin
						st_nxt.req   = 1'b1;
						st_nxt.addr  = src_inc;
						st_nxt.state = ST_RD;
					end
				end
			end
			default: begin
				st_nxt = STATE_RST;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= STATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign busy                   = st_r.busy;
	assign done                   = st_r.done;
	assign word_count_reg_out     = st_r.count;
	assign source_pointer_reg_out = st_r.src;
	assign dest_pointer_reg_out   = st_r.dst;
	assign flags_out              = st_r.flags;
	assign mem_req                = st_r.req;
	assign mem_we                 = st_r.we;
	assign mem_addr               = st_r.addr;
	assign mem_wdata              = st_r.wdata;

endmodule : bcu_block_copy

`default_nettype wire

// File: bcu_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module bcu_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic core_clk,
	input  wire logic rstn,
	bcu_fifo_if.fifo  f
);
	// Depth must be a power of two so the pointers wrap by themselves
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           rd;
		logic [AW-1:0]           wr;
		logic [AW:0]             cnt;
	} bcu_fifo_s;

	bcu_fifo_s r;
	bcu_fifo_s n;
	logic      do_push;
	logic      do_pop;

	assign f.push_ready = (r.cnt != (AW+1)'(DEPTH));
	assign f.pop_valid  = (r.cnt != '0);
	assign f.pop_data   = r.mem[r.rd];

	always_comb begin
		n       = r;
		do_push = f.push_valid && f.push_ready;
		do_pop  = f.pop_ready && f.pop_valid;
		if (do_push) begin
			n.mem[r.wr] = f.push_data;
			n.wr        = r.wr + 1'b1;
		end
		if (do_pop) begin
			n.rd = r.rd + 1'b1;
		end
		if (do_push && !do_pop) begin
			n.cnt = r.cnt + 1'b1;
		end else if (do_pop && !do_push) begin
			n.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

endmodule : bcu_fifo

`default_nettype wire

// File: bcu_fifo_if.sv
`timescale 1ns/10ps
`default_nettype none

interface bcu_fifo_if #(
	parameter int W = 8
);
	logic         push_valid;
	logic         push_ready;
	logic [W-1:0] push_data;
	logic         pop_valid;
	logic         pop_ready;
	logic [W-1:0] pop_data;

	modport user (
		output push_valid,
		output push_data,
		input  push_ready,
		input  pop_valid,
		input  pop_data,
		output pop_ready
	);

	modport fifo (
		input  push_valid,
		input  push_data,
		output push_ready,
		output pop_valid,
		output pop_data,
		input  pop_ready
	);
endinterface : bcu_fifo_if

`default_nettype wire

// File: bcu_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module bcu_mem_model
	import bcu_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic [3:0]        slow,
	input  wire logic              mem_req,
	input  wire logic              mem_we,
	input  wire logic [ADDR_W-1:0] mem_addr,
	input  wire logic [DATA_W-1:0] mem_wdata,
	output logic [DATA_W-1:0]      mem_rdata,
	output logic                   mem_ack
);
	logic [DATA_W-1:0] mem [0:65535];
	logic [3:0]        wait_r;
	logic [DATA_W-1:0] noise_r;

	initial
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'hA5;

	assign mem_ack = mem_req && (wait_r >= slow);
	// Idle bus shows a moving pattern so a stale byte cannot pass
	assign mem_rdata = (mem_ack && !mem_we) ? mem[mem_addr] : noise_r;

	always @(posedge core_clk or negedge rstn)
		if (!rstn) begin
			wait_r <= 4'h0;
			noise_r <= 8'h3C;
		end else begin
			noise_r <= noise_r + 8'h5B;
			wait_r <= (mem_req && !mem_ack) ? wait_r + 4'h1 : 4'h0;
			if (mem_ack && mem_we)
				mem[mem_addr] <= mem_wdata;
		end
endmodule : bcu_mem_model

`default_nettype wire

// File: bcu_pkg.sv
package bcu_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W  = 16;
	localparam int DATA_W  = 8;
	localparam int COUNT_W = 16;
	localparam int FLAG_W  = 8;

	// ------------------------------------------------------------
	// Count register fields
	// ------------------------------------------------------------
	localparam int CNT_LOW_MSB  = 7;
	localparam int CNT_HIGH_LSB = 8;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0]  ADDR_RST  = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
	localparam logic [FLAG_W-1:0]  FLAG_RST  = 8'h00;
	localparam logic [DATA_W-1:0]  DATA_RST  = 8'h00;

	// ------------------------------------------------------------
	// Timing in states (clock cycles at core_clk)
	// ------------------------------------------------------------
	localparam int T_FIXED    = 8;
	localparam int T_PER_BYTE = 4;
	// Cycles spent in PRE; the start cycle itself is the first
	localparam int PRE_CYC    = T_FIXED - 1;
	localparam int PRE_W      = 3;
	localparam logic [PRE_W-1:0] PRE_LOAD = PRE_W'(PRE_CYC - 1);

	// ------------------------------------------------------------
	// Buffering
	// ------------------------------------------------------------
	localparam int FIFO_DEPTH = 8;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PRE,
		ST_RD,
		ST_PUSH,
		ST_POP,
		ST_WR
	} bcu_state_e;

endpackage : bcu_pkg

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench
	import bcu_pkg::*;
;
	logic core_clk = 1'b0, rstn = 1'b0, start = 1'b0, word_mode = 1'b0;
	logic busy, done, mem_req, mem_we, mem_ack;
	logic [COUNT_W-1:0] word_count_reg_in = '0, word_count_reg_out;
	logic [ADDR_W-1:0]  source_pointer_reg_in = '0, dest_pointer_reg_in = '0;
	logic [ADDR_W-1:0]  source_pointer_reg_out, dest_pointer_reg_out, mem_addr;
	logic [FLAG_W-1:0]  flags_in = '0, flags_out;
	logic [DATA_W-1:0]  mem_wdata, mem_rdata, em [int];
	logic [3:0]         slow = '0;
	int n_fail = 0, checks_done = 0, cycles = 0, seed = 32'hAE88BC53;

	bcu_block_copy #(.FIFO_D(FIFO_DEPTH)) i_dut (.*);
	bcu_mem_model i_mem (.*);

	always #5 core_clk = ~core_clk;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	// --------------------------------------------
	// One instruction against the reference copy
	// --------------------------------------------
	task automatic run_op(input logic wm, input logic [15:0] c, s, d,
		input logic [7:0] f, input logic [3:0] w);
		int n, cyc;
		logic [15:0] a;
		n = wm ? int'(c) : int'(c[7:0]);
		for (int i = 0; i < n; i++) begin
			a = s + 16'(i);
			em[d + 16'(i)] = em.exists(a) ? em[a] : i_mem.mem[a];
		end
		@(posedge core_clk);
		word_mode <= wm;
		word_count_reg_in <= c;
		source_pointer_reg_in <= s;
		dest_pointer_reg_in <= d;
		{flags_in, slow, start} <= {f, w, 1'b1};
		@(posedge core_clk);
		start <= 1'b0;
		cyc = 1;
		forever begin
			@(negedge core_clk);
			if (done === 1'b1 || cyc > 9000)
				break;
			@(posedge core_clk);
			cyc++;
			// A second start in mid-run must change nothing
			if (cyc == 3)
				{start, word_count_reg_in} <= {1'b1, ~c};
			if (cyc == 4)
				start <= 1'b0;
		end
		chk("cycles", T_FIXED + T_PER_BYTE * n + 2 * n * w, cyc);
		chk("count", wm ? 16'h0000 : {c[15:8], 8'h00}, word_count_reg_out);
		chk("src", 16'(s + 16'(n)), source_pointer_reg_out);
		chk("dst", 16'(d + 16'(n)), dest_pointer_reg_out);
		chk("flags", f, flags_out);
		chk("busy", 1'b0, busy);
		for (int i = 0; i < n; i++) begin
			a = d + 16'(i);
			chk("byte", em[a], i_mem.mem[a]);
		end
	endtask : run_op

	initial begin
		logic [31:0] r;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		run_op(1'b0, 16'h4700, 16'h0100, 16'h0200, 8'hC3, 4'h0);
		run_op(1'b1, 16'h0000, 16'h0100, 16'h0200, 8'h5A, 4'h0);
		run_op(1'b0, 16'h12FF, 16'h1000, 16'h2000, 8'hFF, 4'h0);
		run_op(1'b1, 16'h0105, 16'h3000, 16'h4000, 8'h81, 4'h0);
		run_op(1'b1, 16'h0005, 16'h0300, 16'h0302, 8'h00, 4'h2);
		run_op(1'b0, 16'h0003, 16'hFFFE, 16'h5000, 8'h24, 4'h3);
		repeat (30) begin
			r = $random(seed);
			run_op(r[0], r[0] ? 16'(r[4:1]) : {r[15:8], 5'h00, r[3:1]},
				16'($random(seed)), 16'($random(seed)), r[23:16], 4'(r[6:5]));
		end
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
